/* dv/mono_output_and_power_control_test.sv */
// testbench for the mono output and power control register block
// assumes the apb slave answers with pready; drives all ports itself, no partner model
module mono_output_and_power_control_test;
    import mono_out_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, arst_n, psel, penable, pwrite, over_temp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, irq, err;
    logic [15:0] outs;
    int fail_count, checked;
    mono_out_ctrl i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .over_temp(over_temp), .irq(irq), .mono_output_mute(outs[15]), .bypass_to_mono_enable(outs[14]),
        .mixer_one_to_mono_enable(outs[13]), .dac_to_mono_enable(outs[12]), .mono_gain_boost(outs[11]),
        .tie_off_buffer_enable(outs[10]), .mono_mixer_enable(outs[9]), .dc_shift_buffer_enable(outs[8]),
        .standby_enable(outs[7]), .mixer_one_enable(outs[6]), .mixer_two_enable(outs[5]),
        .video_buffer_enable(outs[4]), .speaker_neg_enable(outs[3]), .speaker_pos_enable(outs[2]),
        .mono_output_enable(outs[1]), .thermal_protect_enable(outs[0]));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1, "no pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
        chk({31'h0, err}, 32'h0, "read error");
    endtask
    // lets the register and output stages land, then looks at the control outputs
    task automatic outchk(input logic [15:0] exp, input logic exp_irq);
        repeat (3) @(posedge mclk);
        #1;
        chk({16'h0, outs}, {16'h0, exp}, "control outputs");
        chk({31'h0, irq}, {31'h0, exp_irq}, "irq");
    endtask
    task automatic test_reset();
        outchk(16'h1001, 1'b0);
        rdchk(12'h004, 32'h0);
        rdchk(12'h008, 32'h0);
        rdchk(12'h00c, 32'h0);
        rdchk(12'h0c4, 32'h002);
        rdchk(12'h0e0, 32'h001);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        pstrb <= 4'h1;
        apb(1'b1, 12'h0e0, 32'h1fe);
        pstrb <= 4'hf;
        rdchk(12'h0e0, 32'h001);
        apb(1'b1, 12'h0e2, 32'h1fe);
        chk({31'h0, err}, 32'h1, "misaligned error");
        rdchk(12'h0e0, 32'h001);
        $display("test reset done");
    endtask
    task automatic test_mono();
        apb(1'b1, 12'h0e0, 32'h1ff);
        outchk(16'hf001, 1'b0);
        rdchk(12'h0e0, 32'h047);
        apb(1'b1, 12'h0e0, 32'h0);
        outchk(16'h0001, 1'b0);
        $display("test mono done");
    endtask
    task automatic test_power();
        apb(1'b1, 12'h004, 32'h1ff);
        apb(1'b1, 12'h008, 32'h1ff);
        apb(1'b1, 12'h00c, 32'h1ff);
        outchk(16'h07ff, 1'b0);
        rdchk(12'h004, 32'h144);
        rdchk(12'h008, 32'h040);
        rdchk(12'h00c, 32'h0fc);
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        outchk(16'h0001, 1'b0);
        $display("test power done");
    endtask
    task automatic test_boost();
        apb(1'b1, 12'h004, 32'h104);
        apb(1'b1, 12'h0c4, 32'h1ff);
        outchk(16'h0d01, 1'b0);
        rdchk(12'h0c4, 32'h00a);
        apb(1'b1, 12'h0c4, 32'h002);
        outchk(16'h0501, 1'b0);
        $display("test boost done");
    endtask
    task automatic test_thermal();
        apb(1'b1, 12'h004, 32'h004);
        apb(1'b1, 12'h00c, 32'h060);
        apb(1'b1, 12'h0f4, 32'h1);
        outchk(16'h040d, 1'b0);
        @(posedge mclk) over_temp <= 1'b1;
        outchk(16'h0401, 1'b1);
        rdchk(12'h0f0, 32'h1);
        outchk(16'h0401, 1'b0);
        @(posedge mclk) over_temp <= 1'b0;
        outchk(16'h040d, 1'b0);
        apb(1'b1, 12'h0f4, 32'h0);
        @(posedge mclk) over_temp <= 1'b1;
        outchk(16'h0401, 1'b0);
        rdchk(12'h0f0, 32'h1);
        @(posedge mclk) over_temp <= 1'b0;
        apb(1'b1, 12'h0c4, 32'h0);
        apb(1'b1, 12'h0f4, 32'h1);
        @(posedge mclk) over_temp <= 1'b1;
        outchk(16'h040c, 1'b0);
        rdchk(12'h0f0, 32'h0);
        @(posedge mclk) over_temp <= 1'b0;
        $display("test thermal done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        fail_count++;
        finish_test();
    end
    initial begin
        fail_count = 0;
        checked = 0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        over_temp = 1'b0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        test_reset();
        test_mono();
        test_power();
        test_boost();
        test_thermal();
        finish_test();
    end
endmodule

/* hw/mono_out_ctrl.sv */
// mono output path and output power control registers, apb slave, one thermal interrupt
// assumes a synchronous over-temperature level from the analog sensor and an apb master on mclk
//
// Behaviour
// (RULE1) mono mute bit 6 low passes the mono mixer to the output stage, high drives the midrail reference.
// (RULE2) mono mixer bit 2 connects the bypass path and bit 1 connects output mixer 1, 1 meaning connected.
// (RULE3) mono mixer bit 0 connects the dac path and resets to 1.
// (RULE4) mono boost bit 3 high selects non-inverting gain 1.5 with dc level 1.5 times half supply.
// (RULE5) mono boost low selects inverting unity gain at half supply, and the bit resets to 0.
// (RULE6) software enables the dc-shift buffer (power one bit 8) before using boost.
// (RULE7) every power register enable bit is active high and resets to 0.
// (RULE8) power three holds mixer 1, mixer 2, video buffer, speaker neg, speaker pos and mono output at bits 2 to 7.
// (RULE9) power one holds the tie-off buffer at bit 2, mono mixer at bit 6 and dc-shift buffer at bit 8.
// (RULE10) standby bit 6 of standby control selects reduced-current standby and resets to 0.
// (RULE11) an over-temperature level with protection enabled forces both speaker amplifiers off.
// (RULE12) protection enable sits at output control bit 1 and resets to 1.
// (RULE13) a thermal shutdown can raise an interrupt when software unmasks it.
// (RULE14) software should not enable outputs with the tie-off buffer off, or with boost and no dc-shift buffer.
// (RULE15) each register is nine bits and a write acts on its analog control at once.
//
// Local design decision: the APB slave port.
module mono_out_ctrl
    import mono_out_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic over_temp,
    output logic irq,
    output logic mono_output_mute,
    output logic bypass_to_mono_enable,
    output logic mixer_one_to_mono_enable,
    output logic dac_to_mono_enable,
    output logic mono_gain_boost,
    output logic tie_off_buffer_enable,
    output logic mono_mixer_enable,
    output logic dc_shift_buffer_enable,
    output logic standby_enable,
    output logic mixer_one_enable,
    output logic mixer_two_enable,
    output logic video_buffer_enable,
    output logic speaker_neg_enable,
    output logic speaker_pos_enable,
    output logic mono_output_enable,
    output logic thermal_protect_enable
);
    logic [8:0] pwr_one_q;
    logic [8:0] standby_q;
    logic [8:0] pwr_three_q;
    logic [8:0] boost_prot_q;
    logic [8:0] mono_mix_q;
    logic [8:0] irq_stat_q;
    logic [8:0] irq_mask_q;
    logic over_temp_q;
    logic shutdown_q;

    logic [7:0] idx;
    logic aligned;
    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic [8:0] rd_d;
    logic [8:0] wdat;
    logic thermal_event;
    logic mapped;

    assign idx = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign access = psel && penable;
    assign mapped = aligned && (idx == IDX_PWR_ONE || idx == IDX_STANDBY || idx == IDX_PWR_THREE
        || idx == IDX_BOOST_PROT || idx == IDX_MONO_MIX || idx == IDX_IRQ_STATUS
        || idx == IDX_IRQ_MASK);
    // lanes 0 and 1 both needed for a 9-bit field; partial strobes leave the register alone
    assign wr = access && pwrite && hit && (pstrb[1:0] == 2'h3);
    assign rd = access && !pwrite && hit;
    assign wdat = pwdata[8:0];

    always_comb begin
        hit = aligned;
        rd_d = 9'h000;
        unique case (idx)
            IDX_PWR_ONE: rd_d = pwr_one_q;
            IDX_STANDBY: rd_d = standby_q;
            IDX_PWR_THREE: rd_d = pwr_three_q;
            IDX_BOOST_PROT: rd_d = boost_prot_q;
            IDX_MONO_MIX: rd_d = mono_mix_q;
            IDX_IRQ_STATUS: rd_d = irq_stat_q;
            IDX_IRQ_MASK: rd_d = irq_mask_q;
            default: hit = 1'b0;
        endcase
    end

    // zero-wait slave: answers in the first access cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? {23'h000000, rd_d} : 32'h0000_0000;
        end
    end

    logic wr_now;
    assign wr_now = wr && pready;

    // control registers, reaching the analog controls through one output register stage
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_one_q <= RST_PWR_ONE; // RULE7
            standby_q <= RST_STANDBY; // RULE10
            pwr_three_q <= RST_PWR_THREE; // RULE7
            boost_prot_q <= RST_BOOST_PROT; // RULE5 RULE12
            mono_mix_q <= RST_MONO_MIX; // RULE3
            irq_mask_q <= RST_IRQ_MASK;
        end else if (wr_now) begin
            unique case (idx)
                IDX_PWR_ONE: pwr_one_q <= wdat & MSK_PWR_ONE; // RULE9 RULE15
                IDX_STANDBY: standby_q <= wdat & MSK_STANDBY; // RULE10 RULE15
                IDX_PWR_THREE: pwr_three_q <= wdat & MSK_PWR_THREE; // RULE8 RULE15
                IDX_BOOST_PROT: boost_prot_q <= wdat & MSK_BOOST_PROT; // RULE15
                IDX_MONO_MIX: mono_mix_q <= wdat & MSK_MONO_MIX; // RULE15
                IDX_IRQ_MASK: irq_mask_q <= wdat & MSK_IRQ;
                default: ;
            endcase
        end
    end

    // a shutdown event is the rise of over-temperature while protection is on
    assign thermal_event = over_temp && !over_temp_q && boost_prot_q[BIT_THERM_EN]; // RULE13

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            over_temp_q <= 1'b0;
        end else begin
            over_temp_q <= over_temp;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shutdown_q <= 1'b0;
        end else begin
            shutdown_q <= over_temp && boost_prot_q[BIT_THERM_EN]; // RULE11
        end
    end

    // sticky status, cleared by a read, a new event wins over the clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= 9'h000;
        end else begin
            if (rd && pready && idx == IDX_IRQ_STATUS) begin
                irq_stat_q <= 9'h000;
            end
            if (thermal_event) begin
                irq_stat_q[BIT_IRQ_THERM] <= 1'b1; // RULE13
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q); // RULE13
        end
    end

    // analog control outputs, one register stage after the bits
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mono_output_mute <= 1'b0;
            bypass_to_mono_enable <= 1'b0;
            mixer_one_to_mono_enable <= 1'b0;
            dac_to_mono_enable <= 1'b1;
            mono_gain_boost <= 1'b0;
            tie_off_buffer_enable <= 1'b0;
            mono_mixer_enable <= 1'b0;
            dc_shift_buffer_enable <= 1'b0;
            standby_enable <= 1'b0;
            mixer_one_enable <= 1'b0;
            mixer_two_enable <= 1'b0;
            video_buffer_enable <= 1'b0;
            speaker_neg_enable <= 1'b0;
            speaker_pos_enable <= 1'b0;
            mono_output_enable <= 1'b0;
            thermal_protect_enable <= 1'b1;
        end else begin
            mono_output_mute <= mono_mix_q[BIT_MONO_MUTE]; // RULE1
            bypass_to_mono_enable <= mono_mix_q[BIT_BYP_TO_MONO]; // RULE2
            mixer_one_to_mono_enable <= mono_mix_q[BIT_MIX1_TO_MONO]; // RULE2
            dac_to_mono_enable <= mono_mix_q[BIT_DAC_TO_MONO]; // RULE3
            mono_gain_boost <= boost_prot_q[BIT_MONO_BOOST]; // RULE4 RULE5
            tie_off_buffer_enable <= pwr_one_q[BIT_TIE_OFF_EN]; // RULE9
            mono_mixer_enable <= pwr_one_q[BIT_MONO_MIX_EN]; // RULE9
            dc_shift_buffer_enable <= pwr_one_q[BIT_DC_SHIFT_EN]; // RULE9
            standby_enable <= standby_q[BIT_STANDBY]; // RULE10
            mixer_one_enable <= pwr_three_q[BIT_MIX1_EN]; // RULE8
            mixer_two_enable <= pwr_three_q[BIT_MIX2_EN]; // RULE8
            video_buffer_enable <= pwr_three_q[BIT_VBUF_EN]; // RULE8
            speaker_neg_enable <= pwr_three_q[BIT_SPK_NEG_EN] && !(over_temp && boost_prot_q[BIT_THERM_EN]); // RULE11
            speaker_pos_enable <= pwr_three_q[BIT_SPK_POS_EN] && !(over_temp && boost_prot_q[BIT_THERM_EN]); // RULE11
            mono_output_enable <= pwr_three_q[BIT_MONO_OUT_EN]; // RULE8
            thermal_protect_enable <= boost_prot_q[BIT_THERM_EN]; // RULE12
        end
    end

    // assertions
    speaker_cut_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (over_temp && thermal_protect_enable) |=> !speaker_pos_enable && !speaker_neg_enable) // RULE11
        else $error("speaker left on during thermal shutdown");

    sequence apb_write_s(logic [7:0] i);
        psel && penable && pwrite && pready && !pslverr && idx == i && pstrb[1:0] == 2'h3;
    endsequence

    mute_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_MONO_MIX) |=> ##1 (mono_output_mute == $past(pwdata[BIT_MONO_MUTE], 2))) // RULE1
        else $error("mono mute did not follow write");

    mix_paths_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_MONO_MIX) |=> ##1 ({bypass_to_mono_enable, mixer_one_to_mono_enable}
            == $past(pwdata[2:1], 2))) // RULE2
        else $error("mono mixer paths did not follow write");

    dac_path_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_MONO_MIX) |=> ##1 (dac_to_mono_enable == $past(pwdata[BIT_DAC_TO_MONO], 2))) // RULE3
        else $error("dac path did not follow write");

    boost_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_BOOST_PROT) |=> ##1 (mono_gain_boost == $past(pwdata[BIT_MONO_BOOST], 2))) // RULE4
        else $error("mono boost did not follow write");

    protect_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_BOOST_PROT) |=> ##1 (thermal_protect_enable == $past(pwdata[BIT_THERM_EN], 2))) // RULE12
        else $error("protection enable did not follow write");

    standby_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_STANDBY) |=> ##1 (standby_enable == $past(pwdata[BIT_STANDBY], 2))) // RULE10
        else $error("standby did not follow write");

    pwr_three_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_PWR_THREE) |=> ##1 ({mono_output_enable, video_buffer_enable, mixer_two_enable,
            mixer_one_enable} == {$past(pwdata[7], 2), $past(pwdata[4:2], 2)})) // RULE8
        else $error("power three enables did not follow write");

    pwr_one_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_write_s(IDX_PWR_ONE) |=> ##1 ({dc_shift_buffer_enable, mono_mixer_enable, tie_off_buffer_enable}
            == {$past(pwdata[8], 2), $past(pwdata[6], 2), $past(pwdata[2], 2)})) // RULE9
        else $error("power one enables did not follow write");

    therm_irq_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (thermal_event && irq_mask_q[BIT_IRQ_THERM]) |=> ##1 irq) // RULE13
        else $error("thermal event did not raise interrupt");

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    pready_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        apb_setup_s |=> pready) // RULE15
        else $error("pready missing after setup");

    pready_single_a: assert property (@(posedge mclk) disable iff (!arst_n)
        pready |=> !pready) // RULE15
        else $error("pready held for more than one cycle");

    slverr_qual_a: assert property (@(posedge mclk) disable iff (!arst_n)
        pslverr |-> pready) // RULE15
        else $error("error response without pready");

    unmapped_err_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (psel && !penable && !mapped) |=> pslverr) // RULE15
        else $error("unmapped access not refused");

    rdata_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !pready |-> prdata == 32'h0000_0000) // RULE15
        else $error("read data outside the answer cycle");

    rdata_upper_a: assert property (@(posedge mclk) disable iff (!arst_n)
        prdata[31:9] == 23'h000000) // RULE15
        else $error("read data above the register width");

    partial_strobe_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (access && pwrite && idx == IDX_MONO_MIX && pstrb[1:0] != 2'h3) |=> $stable(mono_mix_q)) // RULE15
        else $error("partial strobe write changed the register");

    mix_unused_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (mono_mix_q & ~MSK_MONO_MIX) == 9'h000) // RULE2
        else $error("unused mono mixer bit set");

    pwr_one_unused_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (pwr_one_q & ~MSK_PWR_ONE) == 9'h000) // RULE9
        else $error("unused power one bit set");

    pwr_three_unused_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (pwr_three_q & ~MSK_PWR_THREE) == 9'h000) // RULE8
        else $error("unused power three bit set");

    status_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        thermal_event |=> irq_stat_q[BIT_IRQ_THERM]) // RULE13
        else $error("thermal event not recorded");

    status_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (rd && pready && idx == IDX_IRQ_STATUS && !thermal_event) |=> !irq_stat_q[BIT_IRQ_THERM]) // RULE13
        else $error("status not cleared by read");

    irq_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (|(irq_stat_q & irq_mask_q)) |=> irq) // RULE13
        else $error("interrupt low with unmasked status");

    irq_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !(|(irq_stat_q & irq_mask_q)) |=> !irq) // RULE13
        else $error("interrupt high with no unmasked status");

    shutdown_cut_a: assert property (@(posedge mclk) disable iff (!arst_n)
        shutdown_q |-> !speaker_pos_enable && !speaker_neg_enable) // RULE11
        else $error("speaker on while shutdown holds");

    speaker_pos_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !(over_temp && boost_prot_q[BIT_THERM_EN]) |=> speaker_pos_enable == $past(pwr_three_q[BIT_SPK_POS_EN])) // RULE8
        else $error("positive speaker enable did not follow register");

    speaker_neg_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !(over_temp && boost_prot_q[BIT_THERM_EN]) |=> speaker_neg_enable == $past(pwr_three_q[BIT_SPK_NEG_EN])) // RULE8
        else $error("negative speaker enable did not follow register");

    enables_reset_a: assert property (@(posedge mclk)
        $rose(arst_n) |-> !speaker_pos_enable && !speaker_neg_enable && !mono_output_enable
            && !mixer_one_enable && !mono_gain_boost) // RULE7 RULE5
        else $error("enable not off after reset");
endmodule

/* hw/mono_out_pkg.sv */
// package: register map, field positions and reset values for the mono output and power control block
// assumes apb with 32-bit data; registers are 9 bits in the low bits of a word
package mono_out_pkg;
    localparam int REG_W = 9;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_PWR_ONE = 8'h01;
    localparam logic [7:0] IDX_STANDBY = 8'h02;
    localparam logic [7:0] IDX_PWR_THREE = 8'h03;
    localparam logic [7:0] IDX_BOOST_PROT = 8'h31;
    localparam logic [7:0] IDX_MONO_MIX = 8'h38;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h3c;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h3d;
    // fields
    localparam int BIT_DAC_TO_MONO = 0;
    localparam int BIT_MIX1_TO_MONO = 1;
    localparam int BIT_BYP_TO_MONO = 2;
    localparam int BIT_MONO_MUTE = 6;
    localparam int BIT_THERM_EN = 1;
    localparam int BIT_MONO_BOOST = 3;
    localparam int BIT_TIE_OFF_EN = 2;
    localparam int BIT_MONO_MIX_EN = 6;
    localparam int BIT_DC_SHIFT_EN = 8;
    localparam int BIT_STANDBY = 6;
    localparam int BIT_MIX1_EN = 2;
    localparam int BIT_MIX2_EN = 3;
    localparam int BIT_VBUF_EN = 4;
    localparam int BIT_SPK_NEG_EN = 5;
    localparam int BIT_SPK_POS_EN = 6;
    localparam int BIT_MONO_OUT_EN = 7;
    localparam int BIT_IRQ_THERM = 0;
    // reset values
    localparam logic [8:0] RST_PWR_ONE = 9'h000;
    localparam logic [8:0] RST_STANDBY = 9'h000;
    localparam logic [8:0] RST_PWR_THREE = 9'h000;
    localparam logic [8:0] RST_BOOST_PROT = 9'h002;
    localparam logic [8:0] RST_MONO_MIX = 9'h001;
    localparam logic [8:0] RST_IRQ_MASK = 9'h000;
    // used fields per register
    localparam logic [8:0] MSK_PWR_ONE = 9'h144;
    localparam logic [8:0] MSK_STANDBY = 9'h040;
    localparam logic [8:0] MSK_PWR_THREE = 9'h0fc;
    localparam logic [8:0] MSK_BOOST_PROT = 9'h00a;
    localparam logic [8:0] MSK_MONO_MIX = 9'h047;
    localparam logic [8:0] MSK_IRQ = 9'h001;
endpackage
